// [hdl/psj_map.svh]
/*
 Constants of the preset speed and jog selector: register offsets, field
 positions, reset values and terminal function codes.
 Assumes AHB-Lite word access; frequencies in 0.1 Hz, times in 0.1 s.
*/
// Notes on behaviour
// - Fifteen programmable preset speeds are held
// - Single high, middle, low picks presets 1-3
// - Presets 1-3 reset 50/30/10 Hz, 0-400 Hz
// - Combinations pick presets 4-15; 9999 unselected
// - Presets 4-15 reset to unselected code
// - Extension alone, preset 8 unset: low preset
// - Default overlap gives lower-speed input priority
// - Low, middle, high use function codes 0,1,2
// - Extension select uses function code 8
// - Jog over presets over current over voltage
// - Presets work only in modes 2, 3 or 4
// - Nonzero remote setting disables preset selection
// - Presets 4-15 have no mutual priority
// - Presets writable anytime despite write selection
// - Extended presets writable only when extension zero
// - Jog runs 5 Hz default, 0.5 s ramp
// - Jog ramp refers to reference frequency
// - Jog select code 5; start inputs run jog
// - Panel jog runs only while start held; mode 4 latch keeps jog running after run key release, until stop
// - S-pattern A: jog ramp refers to base
// - Jog ignores second ramp, keeps second functions
// - Mode 4 jog by panel keys; mode 3 none
`ifndef PSJ_MAP_SVH
`define PSJ_MAP_SVH
`define PSJ_A_CTRL   8'h00
`define PSJ_A_TERM   8'h04
`define PSJ_A_JOGF   8'h08
`define PSJ_A_JOGT   8'h0C
`define PSJ_A_REFF   8'h10
`define PSJ_A_BASEF  8'h14
`define PSJ_A_STAT   8'h18
`define PSJ_A_PRE    2'h1
`define PSJ_C_MODE   2:0
`define PSJ_C_REMOTE 5:4
`define PSJ_C_DISPEXT 8
`define PSJ_C_PWS    13:12
`define PSJ_C_SPAT   16
`define PSJ_CTRL_MASK 32'h0001_3137
`define PSJ_PWS_LOCK 2'h1
`define PSJ_RST_CTRL 32'h0000_0002
`define PSJ_RST_TERM 20'h8_5210
`define PSJ_RST_P1   14'h01F4
`define PSJ_RST_P2   14'h012C
`define PSJ_RST_P3   14'h0064
`define PSJ_NOSEL    14'h270F
`define PSJ_FMAX     14'h0FA0
`define PSJ_RST_JOGF 14'h0032
`define PSJ_RST_JOGT 16'h0005
`define PSJ_TMAX     16'h8CA0
`define PSJ_RST_REFF 14'h01F4
`define PSJ_RST_BASE 14'h01F4
`define PSJ_F_LOW    4'h0
`define PSJ_F_MID    4'h1
`define PSJ_F_HIGH   4'h2
`define PSJ_F_RT     4'h3
`define PSJ_F_JOG    4'h5
`define PSJ_F_EXT    4'h8
`endif

// [hdl/psj_pkg.sv]
/*
 Types of the preset speed and jog selector.
 Assumes the constants header is included by the design file.
*/
package psj_pkg;
	// Command source, Gray coded along the priority order
	typedef enum logic [1:0] {
		SRC_VOLT   = 2'b00,
		SRC_CURR   = 2'b01,
		SRC_PRESET = 2'b11,
		SRC_JOG    = 2'b10
	} psj_src_t;

	// Panel jog latch used in combined mode
	typedef enum logic {
		PJ_IDLE = 1'b0,
		PJ_RUN  = 1'b1
	} psj_pj_t;

	// Decoded terminal functions
	typedef struct packed {
		logic high;
		logic mid;
		logic low;
		logic ext;
		logic jog;
		logic rt;
	} psj_sel_t;
endpackage : psj_pkg

// [hdl/psj_selector.sv]
/*
 Preset speed and jog selector: picks the running frequency command from
 contact terminals, panel keys and analog commands; AHB-Lite register slave.
 Assumes one 100 MHz clock, asynchronous low reset, pins from outside.
*/
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "psj_map.svh"
module psj_selector (
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic [31:0]      o_hrdata,
	output logic             o_hresp,
	input  wire logic [4:0]  i_terminal,
	input  wire logic        i_forward_start,
	input  wire logic        i_reverse_start,
	input  wire logic        i_panel_run,
	input  wire logic        i_panel_stop,
	input  wire logic        i_panel_jog,
	input  wire logic [13:0] i_current_cmd,
	input  wire logic        i_current_valid,
	input  wire logic [13:0] i_voltage_cmd,
	output logic [13:0]      o_freq_cmd,
	output logic [1:0]       o_source,
	output logic             o_run,
	output logic             o_reverse,
	output logic             o_jog_active,
	output logic [15:0]      o_ramp_time,
	output logic [13:0]      o_ramp_ref,
	output logic             o_second_ramp,
	output logic             o_second_func
);
	// True when terminal k is on and routed to function f
	function automatic logic func_on(input logic [19:0] t,
		input logic [4:0] p, input logic [3:0] f);
		logic r;
		r = 1'b0;
		for (int k = 0; k < 5; k++) begin
			r = r | (p[k] & (t[4*k +: 4] == f));
		end
		return r;
	endfunction : func_on

	// Preset number for a {ext,high,mid,low} code, one per code
	function automatic logic [3:0] preset_slot(input logic [3:0] c);
		case (c)
			4'h1:    return 4'h3;
			4'h2:    return 4'h2;
			4'h4:    return 4'h1;
			4'h3:    return 4'h4;
			default: return (c == 4'h0) ? 4'h1 : c; // Idle stays in range
		endcase
	endfunction : preset_slot

	// Preset used when the combination holds the unselected code
	function automatic logic [3:0] fallback(input logic [3:0] c);
		if (c[0]) begin
			return 4'h3;
		end else if (c[1]) begin
			return 4'h2;
		end else if (c[2]) begin
			return 4'h1;
		end
		return 4'h3;
	endfunction : fallback

	// Pin synchronisers: three stages, a change counts once 2 and 3 agree
	logic [9:0] raw, s1, s2, s3, pin, next_pin;
	assign raw = {i_terminal, i_forward_start, i_reverse_start,
		i_panel_run, i_panel_stop, i_panel_jog};
	assign next_pin = (s2 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1  <= 10'h000;
			s2  <= 10'h000;
			s3  <= 10'h000;
			pin <= 10'h000;
		end else begin
			s1  <= raw;
			s2  <= s1;
			s3  <= s2;
			pin <= next_pin;
		end
	end

	wire logic [4:0] term_on = pin[9:5];
	wire logic       fwd     = pin[4];
	wire logic       rev     = pin[3];
	wire logic       prun    = pin[2];
	wire logic       pstop   = pin[1];
	wire logic       pjog    = pin[0];

	// Registers
	logic [31:0] ctrl;
	logic [19:0] term;
	logic [13:0] jogf, reff, basef;
	logic [15:0] jogt;
	logic [13:0] preset [15];

	wire logic [2:0] mode    = ctrl[`PSJ_C_MODE];
	wire logic [1:0] remote  = ctrl[`PSJ_C_REMOTE];
	wire logic       dispext = ctrl[`PSJ_C_DISPEXT];
	wire logic       locked  = ctrl[`PSJ_C_PWS] == `PSJ_PWS_LOCK;
	wire logic       spat    = ctrl[`PSJ_C_SPAT];

	// AHB-Lite: writes have no wait state, reads take one
	logic       dp_wr, rd_pend;
	logic [7:0] dp_addr;
	wire logic  accept = i_hsel & i_htrans[1] & i_hready
		& (i_hsize == 3'h2);
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dp_wr       <= 1'b0;
			rd_pend     <= 1'b0;
			dp_addr     <= 8'h00;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			dp_wr       <= accept & i_hwrite;
			rd_pend     <= accept & ~i_hwrite;
			dp_addr     <= accept ? i_haddr[7:0] : dp_addr;
			o_hreadyout <= ~(accept & ~i_hwrite);
			o_hresp     <= 1'b0;
		end
	end

	// Write decode; a read is delayed so it sees the write just before
	wire logic [13:0] wv     = i_hwdata[13:0];
	wire logic        w_top0 = i_hwdata[31:14] == 18'h0_0000;
	wire logic [3:0]  pidx   = dp_addr[5:2];
	wire logic        w_pre  = dp_wr & (dp_addr[7:6] == `PSJ_A_PRE)
		& (pidx != 4'hF);
	wire logic        w_ext  = pidx >= 4'h3;
	wire logic        w_val  = w_top0 & ((wv <= `PSJ_FMAX)
		| (w_ext & (wv == `PSJ_NOSEL)));
	wire logic        w_pok  = w_pre & w_val
		& (~w_ext | ~dispext);
	wire logic        w_par  = dp_wr & ~locked;
	wire logic        w_fok  = w_top0 & (wv <= `PSJ_FMAX);

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl  <= `PSJ_RST_CTRL;
			term  <= `PSJ_RST_TERM;
			jogf  <= `PSJ_RST_JOGF;
			jogt  <= `PSJ_RST_JOGT;
			reff  <= `PSJ_RST_REFF;
			basef <= `PSJ_RST_BASE;
		end else begin
			if (dp_wr && dp_addr == `PSJ_A_CTRL) begin
				ctrl <= i_hwdata & `PSJ_CTRL_MASK;
			end
			if (w_par && dp_addr == `PSJ_A_TERM) begin
				term <= i_hwdata[19:0];
			end
			if (w_par && w_fok && dp_addr == `PSJ_A_JOGF) begin
				jogf <= wv;
			end
			if (w_par && dp_addr == `PSJ_A_JOGT
				&& i_hwdata[31:16] == 16'h0000
				&& i_hwdata[15:0] <= `PSJ_TMAX) begin
				jogt <= i_hwdata[15:0];
			end
			if (w_par && w_fok && dp_addr == `PSJ_A_REFF) begin
				reff <= wv;
			end
			if (w_par && w_fok && dp_addr == `PSJ_A_BASEF) begin
				basef <= wv;
			end
		end
	end

	// Preset store
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			preset[0] <= `PSJ_RST_P1;
			preset[1] <= `PSJ_RST_P2;
			preset[2] <= `PSJ_RST_P3;
			for (int k = 3; k < 15; k++) begin
				preset[k] <= `PSJ_NOSEL;
			end
		end else if (w_pok) begin
			preset[pidx] <= wv;
		end
	end

	// Terminal function decode
	psj_pkg::psj_sel_t sel;
	assign sel.high = func_on(term, term_on, `PSJ_F_HIGH);
	assign sel.mid  = func_on(term, term_on, `PSJ_F_MID);
	assign sel.low  = func_on(term, term_on, `PSJ_F_LOW);
	assign sel.ext  = func_on(term, term_on, `PSJ_F_EXT);
	assign sel.jog  = func_on(term, term_on, `PSJ_F_JOG);
	assign sel.rt   = func_on(term, term_on, `PSJ_F_RT);

	// Preset selection; each code has exactly one preset
	wire logic [3:0]  code   = {sel.ext, sel.high, sel.mid, sel.low};
	wire logic        ms_md  = mode == 3'h2 || mode == 3'h3
		|| mode == 3'h4;
	wire logic        ms_ok  = ms_md && remote == 2'h0
		&& code != 4'h0;
	wire logic [3:0]  slot   = preset_slot(code) - 4'h1;
	wire logic [3:0]  fslot  = fallback(code) - 4'h1;
	wire logic [13:0] pv     = preset[slot];
	wire logic [13:0] chosen = (pv == `PSJ_NOSEL)
		? preset[fslot] : pv;

	// Jog sources: terminal jog, mode 4 panel keys, panel jog mode
	psj_pkg::psj_pj_t pj, next_pj;
	logic             prun_d;
	wire logic        prun_rise = prun & ~prun_d;
	wire logic        fwdrev    = fwd | rev;
	wire logic        ext_jog   = sel.jog & fwdrev
		& (mode == 3'h0 || mode == 3'h2);
	wire logic        pu_jog    = pjog & prun
		& (mode == 3'h0 || mode == 3'h1);
	wire logic        jog_now   = ext_jog | pu_jog
		| (pj == psj_pkg::PJ_RUN);

	// Mode 4: run key starts jog, stop key or mode change ends it
	always_comb begin
		case (pj)
			psj_pkg::PJ_IDLE: next_pj = (sel.jog && mode == 3'h4
				&& prun_rise) ? psj_pkg::PJ_RUN
				: psj_pkg::PJ_IDLE;
			psj_pkg::PJ_RUN: next_pj = (pstop || !sel.jog
				|| mode != 3'h4) ? psj_pkg::PJ_IDLE
				: psj_pkg::PJ_RUN;
			default: next_pj = psj_pkg::PJ_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pj     <= psj_pkg::PJ_IDLE;
			prun_d <= 1'b0;
		end else begin
			pj     <= next_pj;
			prun_d <= prun;
		end
	end

	// Command arbitration by priority
	psj_pkg::psj_src_t next_src;
	logic [13:0]       next_freq;
	always_comb begin
		if (jog_now) begin
			next_src  = psj_pkg::SRC_JOG;
			next_freq = jogf;
		end else if (ms_ok) begin
			next_src  = psj_pkg::SRC_PRESET;
			next_freq = chosen;
		end else if (i_current_valid) begin
			next_src  = psj_pkg::SRC_CURR;
			next_freq = i_current_cmd;
		end else begin
			next_src  = psj_pkg::SRC_VOLT;
			next_freq = i_voltage_cmd;
		end
	end

	// Registered outputs; ramp reference follows the S-pattern choice
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_freq_cmd    <= 14'h0000;
			o_source      <= 2'h0;
			o_run         <= 1'b0;
			o_reverse     <= 1'b0;
			o_jog_active  <= 1'b0;
			o_ramp_time   <= 16'h0000;
			o_ramp_ref    <= 14'h0000;
			o_second_ramp <= 1'b0;
			o_second_func <= 1'b0;
		end else begin
			o_freq_cmd    <= next_freq;
			o_source      <= next_src;
			o_run         <= jog_now | (fwdrev & ~sel.jog);
			o_reverse     <= rev & ~fwd & ~pu_jog
				& (pj == psj_pkg::PJ_IDLE);
			o_jog_active  <= jog_now;
			o_ramp_time   <= jogt;
			o_ramp_ref    <= spat ? basef : reff;
			o_second_ramp <= sel.rt & ~jog_now;
			o_second_func <= sel.rt;
		end
	end

	// Read data, taken in the wait cycle of a read
	logic [31:0] rmux;
	wire  logic [31:0] stat = {4'h0, code, 3'h0, o_jog_active,
		2'h0, o_source, 2'h0, o_freq_cmd};
	always_comb begin
		rmux = 32'h0000_0000;
		if (dp_addr[7:6] == `PSJ_A_PRE && dp_addr[5:2] != 4'hF) begin
			rmux = {18'h0_0000, preset[dp_addr[5:2]]};
		end else begin
			case (dp_addr)
				`PSJ_A_CTRL:  rmux = ctrl;
				`PSJ_A_TERM:  rmux = {12'h000, term};
				`PSJ_A_JOGF:  rmux = {18'h0_0000, jogf};
				`PSJ_A_JOGT:  rmux = {16'h0000, jogt};
				`PSJ_A_REFF:  rmux = {18'h0_0000, reff};
				`PSJ_A_BASEF: rmux = {18'h0_0000, basef};
				`PSJ_A_STAT:  rmux = stat;
				default:      rmux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_hrdata <= 32'h0000_0000;
		end else if (rd_pend) begin
			o_hrdata <= rmux;
		end
	end

	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	AST_JOG_FREQ: assert property (jog_now |=>
		o_freq_cmd == $past(jogf) && o_source == 2'b10)
		else $error("jog command wrong");
	AST_REMOTE_OFF: assert property (remote != 2'h0 && !jog_now
		|=> o_source != 2'b11) else $error("preset with remote");
	AST_MODE_GATE: assert property (!ms_md && !jog_now
		|=> o_source != 2'b11) else $error("preset in bad mode");
	AST_MODE3_NOJOG: assert property ($past(mode) == 3'h3
		&& mode == 3'h3 |=> !o_jog_active) else $error("jog in mode 3");
	AST_HIGH_ONLY: assert property (ms_ok && !jog_now && code == 4'h4
		|=> o_freq_cmd == $past(preset[0])) else $error("high wrong");
	AST_LOW_PRIO: assert property (ms_ok && !jog_now && code == 4'h6
		&& preset[5] == `PSJ_NOSEL |=> o_freq_cmd == $past(preset[1]))
		else $error("overlap priority wrong");
	AST_EXT_ONLY: assert property (ms_ok && !jog_now && code == 4'h8
		&& preset[7] == `PSJ_NOSEL |=> o_freq_cmd == $past(preset[2]))
		else $error("extension fallback wrong");
	AST_RT_JOG: assert property (o_jog_active |-> !o_second_ramp
		&& o_second_func == $past(sel.rt)) else $error("rt in jog");
	AST_EXT_LOCK: assert property (w_pre && w_ext && dispext
		|=> preset[$past(pidx)] == $past(preset[pidx]))
		else $error("locked write");
	AST_PASS: assert property (!jog_now && !ms_ok
		&& !i_current_valid |=> o_freq_cmd == $past(i_voltage_cmd) ##1 1)
		else $error("analog pass wrong");
	AST_RAMP_REF: assert property (spat ##1 spat |->
		o_ramp_ref == $past(basef)) else $error("ramp reference wrong");
	AST_PANEL_HOLD: assert property (pu_jog ##1 !prun && !ext_jog
		&& pj == psj_pkg::PJ_IDLE |=> !o_jog_active)
		else $error("panel jog held");

	COV_JOG: cover property (ext_jog ##1 o_jog_active);
	COV_PRESET: cover property (ms_ok && code == 4'hF && !jog_now);
	COV_MODE4: cover property (pj == psj_pkg::PJ_RUN ##1 pstop);
	COV_READ: cover property (rd_pend ##1 o_hreadyout);
endmodule : psj_selector

// [tb/psj_contacts.sv]
/*
 Model of the contact inputs and operator panel facing the selector.
 Assumes the bench changes its request levels just after a rising edge.
*/
`timescale 1ns/1ns
module psj_contacts (
	input  wire logic       i_clock,
	input  wire logic       i_slow,
	input  wire logic [9:0] i_req,
	output logic [4:0]      o_terminal,
	output logic            o_forward_start,
	output logic            o_reverse_start,
	output logic            o_panel_run,
	output logic            o_panel_stop,
	output logic            o_panel_jog
);
	logic [9:0] stage = 10'h000;
	logic [9:0] held  = 10'h000;

	// Slow contacts close a cycle late, as a tired relay would
	always @(posedge i_clock) begin
		stage <= i_req;
		held  <= i_slow ? stage : i_req;
	end

	// Levels stay put between changes; contacts never float
	assign o_terminal      = held[4:0];
	assign o_forward_start = held[5];
	assign o_reverse_start = held[6];
	assign o_panel_run     = held[7];
	assign o_panel_stop    = held[8];
	assign o_panel_jog     = held[9];
endmodule : psj_contacts

// [tb/preset_speed_jog_selector_test.sv]
/*
 Self-checking bench of the selector: AHB-Lite tasks and pin scenarios.
 Assumes the contact model drives the pins and fixed pin latency of 5.
*/
`timescale 1ns/1ns
`include "psj_map.svh"
module preset_speed_jog_selector_test;
	logic        clock, arst_n, hsel, hwrite, hready, hresp, slow;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, source;
	logic [2:0]  hsize;
	logic [9:0]  req;
	logic [4:0]  terminal;
	logic        fwd, rev, prun, pstop, pjog, cur_valid;
	logic [13:0] cur_cmd, volt_cmd, freq, ramp_ref;
	logic        run, reverse, jog, sec_ramp, sec_func;
	logic [15:0] ramp_time;
	int          err_count, n_checks;
	int          cycles = 0;

	psj_contacts i_contacts (.i_clock(clock), .i_slow(slow), .i_req(req),
		.o_terminal(terminal), .o_forward_start(fwd),
		.o_reverse_start(rev), .o_panel_run(prun), .o_panel_stop(pstop),
		.o_panel_jog(pjog));

	psj_selector i_dut (.i_clock(clock), .i_arst_n(arst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
		.i_terminal(terminal), .i_forward_start(fwd),
		.i_reverse_start(rev), .i_panel_run(prun), .i_panel_stop(pstop),
		.i_panel_jog(pjog), .i_current_cmd(cur_cmd),
		.i_current_valid(cur_valid), .i_voltage_cmd(volt_cmd),
		.o_freq_cmd(freq), .o_source(source), .o_run(run),
		.o_reverse(reverse), .o_jog_active(jog), .o_ramp_time(ramp_time),
		.o_ramp_ref(ramp_ref), .o_second_ramp(sec_ramp),
		.o_second_func(sec_func));

	// Free-running 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Watchdog: the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			give_verdict();
		end
	end

	task give_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One single word transfer; waits for hready in both phases
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize  <= 3'h2;
		haddr  <= {24'h00_0000, a};
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		rd = hrdata;
		chk("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
	endtask : ahb

	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask : wr

	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0000_0000);
		chk(n, rd, e);
	endtask : rchk

	// Pin change, then the fixed sync and decode latency with margin
	task pins(input logic [9:0] r);
		@(posedge clock);
		req <= r;
		repeat (10) @(posedge clock);
	endtask : pins

	function logic [7:0] pa(input int i);
		pa = {`PSJ_A_PRE, 6'h00} + 8'(4 * i - 4);
	endfunction : pa

	// Preset values used once 4 to 15 are programmed
	function logic [31:0] pval(input int i);
		pval = i == 1 ? `PSJ_RST_P1 : i == 2 ? `PSJ_RST_P2 :
			i == 3 ? `PSJ_RST_P3 : 32'(1000 + 16 * i);
	endfunction : pval

	// Unset presets fall back to the lowest active single input
	function logic [31:0] dflt(input int c);
		dflt = c[0] ? `PSJ_RST_P3 : c[1] ? `PSJ_RST_P2 :
			c[2] ? `PSJ_RST_P1 : `PSJ_RST_P3;
	endfunction : dflt

	function int idx(input int c);
		idx = c == 1 ? 3 : c == 2 ? 2 : c == 3 ? 4 : c == 4 ? 1 : c;
	endfunction : idx

	// Main sequence
	initial begin
		int i;
		arst_n = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
		hwrite = 1'b0; hsize = 3'h0; hwdata = 32'h0000_0000; slow = 1'b0;
		req = 10'h000; cur_cmd = 14'h08AE; volt_cmd = 14'h04D2;
		cur_valid = 1'b0; err_count = 0; n_checks = 0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		rchk("ctrl", `PSJ_A_CTRL, `PSJ_RST_CTRL);
		rchk("term", `PSJ_A_TERM, `PSJ_RST_TERM);
		rchk("jogf", `PSJ_A_JOGF, `PSJ_RST_JOGF);
		rchk("jogt", `PSJ_A_JOGT, `PSJ_RST_JOGT);
		rchk("unmapped", 8'h30, 32'h0000_0000);
		for (i = 1; i < 16; i++)
			rchk("preset", pa(i), i < 4 ? pval(i) : `PSJ_NOSEL);
		$display("Test reset done");
		pins(10'h000);
		chk("freq", freq, volt_cmd);
		@(posedge clock);
		cur_valid <= 1'b1;
		pins(10'h000);
		chk("freq", freq, cur_cmd);
		chk("src", source, psj_pkg::SRC_CURR);
		for (i = 1; i < 16; i++) begin
			pins({5'h00, i[3], 1'b0, i[2:0]});
			chk("freq", freq, dflt(i));
		end
		chk("src", source, psj_pkg::SRC_PRESET);
		$display("Test default presets done");
		for (i = 4; i < 16; i++)
			wr(pa(i), pval(i));
		for (i = 1; i < 16; i++) begin
			pins({5'h00, i[3], 1'b0, i[2:0]});
			chk("freq", freq, pval(idx(i)));
		end
		rchk("status", `PSJ_A_STAT, 32'h0F03_0000 | pval(15));
		$display("Test programmed presets done");
		wr(pa(1), 32'h0000_0FA0);
		rchk("preset1", pa(1), 32'h0000_0FA0);
		wr(pa(1), 32'h0000_0FA1);
		rchk("preset1", pa(1), 32'h0000_0FA0);
		wr(pa(1), `PSJ_RST_P1);
		wr(`PSJ_A_CTRL, 32'h0000_1002);
		wr(pa(2), 32'h0000_015E);
		rchk("preset2", pa(2), 32'h0000_015E);
		wr(`PSJ_A_JOGF, 32'h0000_0063);
		rchk("jogf", `PSJ_A_JOGF, `PSJ_RST_JOGF);
		wr(`PSJ_A_CTRL, 32'h0000_0102);
		wr(pa(4), 32'h0000_0309);
		rchk("preset4", pa(4), pval(4));
		$display("Test writes done");
		pins(10'h004);
		for (i = 0; i < 5; i++) begin
			wr(`PSJ_A_CTRL, i == 0 ? 32'h0000_0012 : 32'(i));
			repeat (4) @(posedge clock);
			chk("freq", freq, i < 2 ? cur_cmd : `PSJ_RST_P1);
		end
		wr(`PSJ_A_CTRL, `PSJ_RST_CTRL);
		wr(`PSJ_A_TERM, 32'h0008_5102);
		pins(10'h001);
		chk("freq", freq, `PSJ_RST_P1);
		pins(10'h002);
		chk("freq", freq, `PSJ_RST_P3);
		wr(`PSJ_A_TERM, 32'h0008_5108);
		pins(10'h001);
		chk("freq", freq, pval(8));
		$display("Test modes and routing done");
		// Slow contacts for the terminal jog scenarios
		@(posedge clock);
		slow <= 1'b1;
		wr(`PSJ_A_TERM, 32'h0003_5210);
		wr(`PSJ_A_JOGF, 32'h0000_004B);
		wr(`PSJ_A_JOGT, 32'h0000_8CA1);
		rchk("jogt", `PSJ_A_JOGT, `PSJ_RST_JOGT);
		wr(`PSJ_A_JOGT, `PSJ_TMAX);
		pins(10'h03C);
		chk("freq", freq, 32'h0000_004B);
		chk("src", source, psj_pkg::SRC_JOG);
		chk("jog", jog, 1'b1);
		chk("run", run, 1'b1);
		chk("ramp", ramp_time, `PSJ_TMAX);
		chk("ref", ramp_ref, `PSJ_RST_REFF);
		chk("sfunc", sec_func, 1'b1);
		chk("sramp", sec_ramp, 1'b0);
		wr(`PSJ_A_BASEF, 32'h0000_0258);
		wr(`PSJ_A_CTRL, 32'h0001_0002);
		repeat (4) @(posedge clock);
		chk("ref", ramp_ref, 32'h0000_0258);
		pins(10'h05C);
		chk("rev", reverse, 1'b1);
		pins(10'h034);
		chk("jog", jog, 1'b0);
		chk("sramp", sec_ramp, 1'b1);
		chk("rev", reverse, 1'b0);
		chk("freq", freq, `PSJ_RST_P1);
		pins(10'h01C);
		chk("run", run, 1'b0);
		$display("Test terminal jog done");
		@(posedge clock);
		slow <= 1'b0;
		wr(`PSJ_A_CTRL, 32'h0000_0001);
		pins(10'h280);
		chk("jog", jog, 1'b1);
		chk("freq", freq, 32'h0000_004B);
		pins(10'h200);
		chk("jog", jog, 1'b0);
		wr(`PSJ_A_CTRL, 32'h0000_0004);
		pins(10'h008);
		pins(10'h088);
		pins(10'h008);
		chk("jog", jog, 1'b1);
		pins(10'h108);
		chk("jog", jog, 1'b0);
		wr(`PSJ_A_CTRL, 32'h0000_0003);
		pins(10'h028);
		chk("jog", jog, 1'b0);
		$display("Test panel jog done");
		give_verdict();
	end
endmodule : preset_speed_jog_selector_test
